// file: rtl/watchdog_reset_timer.sv
// Purpose: Watchdog reset timer with control register on an AXI4-Lite slave.
// Assumes: Low-speed oscillator clock and reset sources arrive asynchronously.
// Notes: Restart uses its own alias address; see handover.
`timescale 1ns/100ps
`include "watchdog_reset_timer_map.svh"

module watchdog_reset_timer (
    input wire logic clk,
    input wire logic rst,
    input wire logic [`WDT_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output watchdog_reset_timer_pkg::axi_resp_type s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [`WDT_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output watchdog_reset_timer_pkg::axi_resp_type s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic rc_clk_in,
    input wire logic external_reset_pin_n,
    input wire logic power_on_reset,
    input wire logic low_voltage_reset,
    input wire logic standby_active,
    output logic rc_osc_enable,
    output logic watchdog_reset
);
    import watchdog_reset_timer_pkg::*;

    localparam control_state_type RESET_STATE = '{exit_ticks: `WDT_EXIT_GUARD, pin_sync: 2'b11, default: '0};

    control_state_type state_q;
    control_state_type state_d;
    wdt_counter_if cnt_bus ();

    logic run;
    logic rc_edge;
    logic clear_all;
    logic write_fire;
    logic ctrl_write;
    logic restart;
    logic pause;
    logic standby_entry;
    standby_mode_type mode;

    // Map a byte address onto a register: 01 control, 10 restart alias, 00 unmapped
    function automatic logic [1:0] decode(input logic [`WDT_ADDR_W-1:0] a);
        logic [`WDT_ADDR_W-1:0] word;
        word = {a[`WDT_ADDR_W-1:2], 2'b00};
        if (word == `WDT_CTRL_ADDR) begin
            return 2'b01;
        end else if (word == `WDT_RESTART_ADDR) begin
            return 2'b10;
        end
        return 2'b00;
    endfunction : decode

    // ****************************************
    // Decoded events
    // ****************************************
    assign run = state_q.ctrl[`WDT_RUN_BIT];
    assign mode = standby_mode_type'(state_q.ctrl[`WDT_STBY_HI:`WDT_STBY_LO]);
    assign rc_edge = state_q.rc_sync[1] && !state_q.rc_sync[2];
    assign clear_all = !state_q.pin_sync[1] || state_q.por_sync[1] || state_q.lvd_sync[1];
    assign write_fire = state_q.aw_held && state_q.w_held && !state_q.bvalid;
    assign ctrl_write = write_fire && (decode(state_q.aw_addr) == 2'b01) && state_q.w_strb[0];
    assign restart = write_fire && (decode(state_q.aw_addr) == 2'b10) && state_q.w_strb[0]
                     && (state_q.w_data[7:0] == `WDT_RESTART_KEY) && run;
    assign pause = standby_active && ((mode == STBY_STOP) || (mode == STBY_HOLD));
    assign standby_entry = standby_active && !state_q.standby_prev;

    // Counter steering
    assign cnt_bus.tick = rc_edge && run && !pause;
    assign cnt_bus.clear = !run || restart;
    assign cnt_bus.select = state_q.ctrl[`WDT_SEL_HI:`WDT_SEL_LO];

    wdt_up_counter counter_inst (
        .clk(clk),
        .rst(rst),
        .bus(cnt_bus)
    );

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        state_d = state_q;
        // Synchronisers for asynchronous inputs
        state_d.rc_sync = {state_q.rc_sync[1:0], rc_clk_in};
        state_d.pin_sync = {state_q.pin_sync[0], external_reset_pin_n};
        state_d.por_sync = {state_q.por_sync[0], power_on_reset};
        state_d.lvd_sync = {state_q.lvd_sync[0], low_voltage_reset};
        state_d.wdt_reset = 1'b0;

        // Write address and data are taken independently
        if (s_axi_awvalid && !state_q.aw_held) begin
            state_d.aw_held = 1'b1;
            state_d.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !state_q.w_held) begin
            state_d.w_held = 1'b1;
            state_d.w_data = s_axi_wdata;
            state_d.w_strb = s_axi_wstrb;
        end
        if (write_fire) begin
            state_d.aw_held = 1'b0;
            state_d.w_held = 1'b0;
            state_d.bvalid = 1'b1;
            state_d.bresp = (decode(state_q.aw_addr) == 2'b00) ? `WDT_RESP_SLVERR : `WDT_RESP_OKAY;
        end else if (s_axi_bready) begin
            state_d.bvalid = 1'b0;
        end

        // Read answer one cycle after the address is taken
        if (s_axi_arvalid && !state_q.rvalid) begin
            state_d.rvalid = 1'b1;
            state_d.rresp = (decode(s_axi_araddr) == 2'b00) ? `WDT_RESP_SLVERR : `WDT_RESP_OKAY;
            state_d.rdata = (decode(s_axi_araddr) == 2'b01) ? {24'h000000, state_q.ctrl} : 32'h00000000;
        end else if (s_axi_rready) begin
            state_d.rvalid = 1'b0;
        end

        // Control register: locked while running, restart alias stores nothing
        if (ctrl_write && !run) begin
            state_d.ctrl = state_q.w_data[7:0];
        end
        if (cnt_bus.overflow) begin
            state_d.ctrl = {1'b1, 1'b0, 1'b0, state_q.ctrl[`WDT_KEEP_HI:0]};
            state_d.wdt_reset = 1'b1;
        end
        if (clear_all) begin
            state_d.ctrl = `WDT_CTRL_RESET;
        end

        // Oscillator ticks seen since the last standby exit, saturating
        state_d.standby_prev = standby_active;
        if (!standby_active && state_q.standby_prev) begin
            state_d.exit_ticks = 3'h0;
        end else if (rc_edge && !standby_active && (state_q.exit_ticks < `WDT_EXIT_GUARD)) begin
            state_d.exit_ticks = state_q.exit_ticks + 3'h1;
        end

        // Early re-entry in hold mode leaves the oscillator running
        if (standby_entry) begin
            state_d.osc_keep = (mode == STBY_HOLD) && (state_q.exit_ticks < `WDT_EXIT_GUARD);
        end else if (!standby_active) begin
            state_d.osc_keep = 1'b0;
        end
        state_d.osc_en = state_d.ctrl[`WDT_RUN_BIT] && !(pause && !state_d.osc_keep);
    end

    // Register the state
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= RESET_STATE;
        end else begin
            state_q <= state_d;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign s_axi_awready = !state_q.aw_held;
    assign s_axi_wready = !state_q.w_held;
    assign s_axi_bvalid = state_q.bvalid;
    assign s_axi_bresp = state_q.bresp;
    assign s_axi_arready = !state_q.rvalid;
    assign s_axi_rvalid = state_q.rvalid;
    assign s_axi_rdata = state_q.rdata;
    assign s_axi_rresp = state_q.rresp;
    assign rc_osc_enable = state_q.osc_en;
    assign watchdog_reset = state_q.wdt_reset;

    // ****************************************
    // Checks
    // ****************************************
    property p_reset_source_clears;
        @(posedge clk) disable iff (rst)
        clear_all |=> state_q.ctrl == `WDT_CTRL_RESET;
    endproperty
    a_reset_source_clears: assert property (p_reset_source_clears) else $error("control not cleared");

    property p_keep_low_bits;
        @(posedge clk) disable iff (rst)
        cnt_bus.overflow && !clear_all |=> state_q.ctrl[4:0] == $past(state_q.ctrl[4:0]);
    endproperty
    a_keep_low_bits: assert property (p_keep_low_bits) else $error("low control bits lost");

    property p_locked;
        @(posedge clk) disable iff (rst)
        run && !cnt_bus.overflow && !clear_all |=> state_q.ctrl == $past(state_q.ctrl);
    endproperty
    a_locked: assert property (p_locked) else $error("control changed while running");

    property p_restart_clears;
        @(posedge clk) disable iff (rst)
        restart |=> cnt_bus.count == 16'h0000 ##1 (cnt_bus.count <= 16'h0001);
    endproperty
    a_restart_clears: assert property (p_restart_clears) else $error("restart did not clear");

    property p_no_stray_clear;
        @(posedge clk) disable iff (rst)
        run && !restart && !clear_all |=> (cnt_bus.count >= $past(cnt_bus.count)) || cnt_bus.overflow;
    endproperty
    a_no_stray_clear: assert property (p_no_stray_clear) else $error("counter cleared without cause");

    property p_osc_follows_run;
        @(posedge clk) disable iff (rst)
        !run && !ctrl_write |=> !rc_osc_enable;
    endproperty
    a_osc_follows_run: assert property (p_osc_follows_run) else $error("oscillator on while stopped");

    property p_overflow_effects;
        @(posedge clk) disable iff (rst)
        cnt_bus.overflow && !clear_all |=> state_q.ctrl[7] && !run && watchdog_reset ##1 !watchdog_reset;
    endproperty
    a_overflow_effects: assert property (p_overflow_effects) else $error("overflow effects missing");

    property p_idle_counter_zero;
        @(posedge clk) disable iff (rst)
        !run ##1 !run |-> cnt_bus.count == 16'h0000;
    endproperty
    a_idle_counter_zero: assert property (p_idle_counter_zero) else $error("counter not clear when idle");

    property p_write_stores;
        @(posedge clk) disable iff (rst)
        ctrl_write && !run && !clear_all |=> state_q.ctrl == $past(state_q.w_data[7:0]);
    endproperty
    a_write_stores: assert property (p_write_stores) else $error("unlocked write not stored");

    property p_standby_freeze;
        @(posedge clk) disable iff (rst)
        pause && run && !restart |=> cnt_bus.count == $past(cnt_bus.count);
    endproperty
    a_standby_freeze: assert property (p_standby_freeze) else $error("count moved in standby");

    property p_early_reentry;
        @(posedge clk) disable iff (rst)
        standby_entry && run && (mode == STBY_HOLD) && (state_q.exit_ticks < `WDT_EXIT_GUARD)
        && !cnt_bus.overflow && !clear_all |=> rc_osc_enable;
    endproperty
    a_early_reentry: assert property (p_early_reentry) else $error("oscillator stopped on early re-entry");

endmodule : watchdog_reset_timer

// file: pkg/watchdog_reset_timer_map.svh
// Purpose: Register map, field positions, reset values and counts of the watchdog reset timer.
// Assumes: Included by bare name; definitions only.
// Notes: Byte address of a register is four times its index.
`ifndef WATCHDOG_RESET_TIMER_MAP_SVH
`define WATCHDOG_RESET_TIMER_MAP_SVH

// ****************************************
// Register map
// ****************************************
`define WDT_ADDR_W 18
`define WDT_CTRL_INDEX 16'hfe79
`define WDT_RESTART_INDEX 16'hfe7a
`define WDT_CTRL_ADDR (18'(`WDT_CTRL_INDEX) << 2)
`define WDT_RESTART_ADDR (18'(`WDT_RESTART_INDEX) << 2)

// ****************************************
// Control register fields and values
// ****************************************
`define WDT_FLAG_BIT 7
`define WDT_TEST_BIT 6
`define WDT_RUN_BIT 5
`define WDT_STBY_HI 4
`define WDT_STBY_LO 3
`define WDT_SEL_HI 2
`define WDT_SEL_LO 0
`define WDT_KEEP_HI 4
`define WDT_CTRL_RESET 8'h00
`define WDT_RESTART_KEY 8'h55

// ****************************************
// Counts and bus answers
// ****************************************
`define WDT_BASE_COUNT 17'h00200
`define WDT_EXIT_GUARD 3'h4
`define WDT_RESP_OKAY 2'h0
`define WDT_RESP_SLVERR 2'h2

`endif

// file: pkg/watchdog_reset_timer_pkg.sv
// Purpose: Types and helpers shared by the watchdog reset timer modules.
// Assumes: The map header supplies all numbers.
// Notes: State of each module is one packed struct.
`include "watchdog_reset_timer_map.svh"

package watchdog_reset_timer_pkg;

    // ****************************************
    // Types
    // ****************************************
    typedef logic [1:0] axi_resp_type;

    typedef enum logic [1:0] {
        STBY_CONTINUE = 2'b00,
        STBY_STOP = 2'b01,
        STBY_HOLD = 2'b10,
        STBY_CONTINUE_ALT = 2'b11
    } standby_mode_type;

    typedef struct packed {
        logic [15:0] count;
        logic overflow;
    } counter_state_type;

    typedef struct packed {
        logic [7:0] ctrl;
        logic aw_held;
        logic [`WDT_ADDR_W-1:0] aw_addr;
        logic w_held;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [2:0] rc_sync;
        logic [1:0] pin_sync;
        logic [1:0] por_sync;
        logic [1:0] lvd_sync;
        logic standby_prev;
        logic [2:0] exit_ticks;
        logic osc_keep;
        logic osc_en;
        logic wdt_reset;
    } control_state_type;

    // Last count before the selected terminal count is reached
    function automatic logic [15:0] terminal_last(input logic [2:0] sel);
        logic [16:0] span;
        span = `WDT_BASE_COUNT << sel;
        return span[15:0] - 16'h0001;
    endfunction : terminal_last

endpackage : watchdog_reset_timer_pkg

// file: pkg/wdt_counter_if.sv
// Purpose: Connection between the control logic and the up-counter.
// Assumes: Single clock domain.
// Notes: Overflow is a one-cycle pulse from a flip-flop.
`timescale 1ns/100ps

interface wdt_counter_if;
    logic tick;
    logic clear;
    logic [2:0] select;
    logic [15:0] count;
    logic overflow;

    modport control (output tick, output clear, output select, input count, input overflow);
    modport counter (input tick, input clear, input select, output count, output overflow);
endinterface : wdt_counter_if

// file: rtl/wdt_up_counter.sv
// Purpose: 16-bit watchdog up-counter with selectable terminal count.
// Assumes: Tick is a one-cycle enable per low-speed oscillator edge.
// Notes: Clear has priority over counting.
`timescale 1ns/100ps

module wdt_up_counter (
    input wire logic clk,
    input wire logic rst,
    wdt_counter_if.counter bus
);
    import watchdog_reset_timer_pkg::*;

    counter_state_type state_q;
    counter_state_type state_d;
    logic [15:0] last;

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        last = terminal_last(bus.select);
        state_d = state_q;
        state_d.overflow = 1'b0;
        if (bus.clear) begin
            state_d.count = 16'h0000;
        end else if (bus.tick) begin
            if (state_q.count == last) begin
                state_d.count = 16'h0000;
                state_d.overflow = 1'b1;
            end else begin
                state_d.count = state_q.count + 16'h0001;
            end
        end
    end

    // Register the state
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign bus.count = state_q.count;
    assign bus.overflow = state_q.overflow;

    // ****************************************
    // Checks
    // ****************************************
    property p_tick_advance;
        @(posedge clk) disable iff (rst)
        bus.tick && !bus.clear && (bus.count != last) |=> bus.count == $past(bus.count) + 16'h0001;
    endproperty
    a_tick_advance: assert property (p_tick_advance) else $error("counter did not advance on tick");

    property p_terminal_match;
        @(posedge clk) disable iff (rst)
        bus.tick && !bus.clear && (bus.count == last) |=> bus.overflow && (bus.count == 16'h0000);
    endproperty
    a_terminal_match: assert property (p_terminal_match) else $error("overflow missed at terminal");

    property p_no_early_overflow;
        @(posedge clk) disable iff (rst)
        bus.overflow |-> $past(bus.count) == terminal_last($past(bus.select));
    endproperty
    a_no_early_overflow: assert property (p_no_early_overflow) else $error("overflow off terminal");

endmodule : wdt_up_counter

// file: sim/test_watchdog_reset_timer.sv
// Purpose: Self-checking bench for the watchdog reset timer through its AXI4-Lite port.
// Assumes: Oscillator ticks are driven by the bench at eight system clocks per tick.
// Notes: Overflow pulses are counted by a monitor and compared against running totals.
`timescale 1ns/100ps
`include "watchdog_reset_timer_map.svh"

module test_watchdog_reset_timer;
    import watchdog_reset_timer_pkg::*;

    // ****************************************
    // Signals
    // ****************************************
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [`WDT_ADDR_W-1:0] s_axi_awaddr = '0;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_awready;
    logic [31:0] s_axi_wdata = '0;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_wready;
    axi_resp_type s_axi_bresp;
    logic s_axi_bvalid;
    logic s_axi_bready = 1'b0;
    logic [`WDT_ADDR_W-1:0] s_axi_araddr = '0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_arready;
    logic [31:0] s_axi_rdata;
    axi_resp_type s_axi_rresp;
    logic s_axi_rvalid;
    logic s_axi_rready = 1'b0;
    logic rc_clk_in = 1'b0;
    logic external_reset_pin_n = 1'b1;
    logic power_on_reset = 1'b0;
    logic low_voltage_reset = 1'b0;
    logic standby_active = 1'b0;
    logic rc_osc_enable;
    logic watchdog_reset;
    int n_errors = 0;
    int checked = 0;
    logic [31:0] pulses = '0;
    localparam logic [`WDT_ADDR_W-1:0] CTRL = `WDT_CTRL_ADDR;
    localparam logic [`WDT_ADDR_W-1:0] RESTART = `WDT_RESTART_ADDR;
    localparam logic [`WDT_ADDR_W-1:0] HOLE = 18'h00000;

    // ****************************************
    // Clock, design and overflow monitor
    // ****************************************
    // System clock, 25 ns period
    always #12.5 clk = ~clk;

    watchdog_reset_timer uut (
        .clk(clk), .rst(rst),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .rc_clk_in(rc_clk_in),
        .external_reset_pin_n(external_reset_pin_n), .power_on_reset(power_on_reset),
        .low_voltage_reset(low_voltage_reset), .standby_active(standby_active),
        .rc_osc_enable(rc_osc_enable), .watchdog_reset(watchdog_reset)
    );

    // Counts watchdog reset pulses
    always @(posedge clk) begin
        if (watchdog_reset === 1'b1) begin
            pulses <= pulses + 32'h1;
        end
    end

    // ****************************************
    // Tasks
    // ****************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : finish_test

    // Full write: both channels offered together, held until taken
    task automatic wr(input logic [`WDT_ADDR_W-1:0] a, input logic [31:0] d, input axi_resp_type er);
        bit done;
        done = 0;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hf;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (int n = 0; n < 100 && !done; n++) begin
            @(posedge clk);
            if (s_axi_awvalid && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1) begin
                check(32'(s_axi_bresp), 32'(er));
                s_axi_bready <= 1'b0;
                done = 1;
            end
        end
        if (!done) check(32'h0, 32'h1);
    endtask : wr

    // Full read with data and response compare
    task automatic rd(input logic [`WDT_ADDR_W-1:0] a, input logic [31:0] ed, input axi_resp_type er);
        bit done;
        done = 0;
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (int n = 0; n < 100 && !done; n++) begin
            @(posedge clk);
            if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1) begin
                check(s_axi_rdata, ed);
                check(32'(s_axi_rresp), 32'(er));
                s_axi_rready <= 1'b0;
                done = 1;
            end
        end
        if (!done) check(32'h0, 32'h1);
    endtask : rd

    // Oscillator ticks, eight system clocks each
    task automatic ticks(input int n);
        repeat (n) begin
            @(posedge clk);
            rc_clk_in <= 1'b1;
            repeat (4) @(posedge clk);
            rc_clk_in <= 1'b0;
            repeat (3) @(posedge clk);
        end
        repeat (8) @(posedge clk);
    endtask : ticks

    // ****************************************
    // Test sequence
    // ****************************************
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        rd(CTRL, 32'h00, `WDT_RESP_OKAY);
        rd(HOLE, 32'h00, `WDT_RESP_SLVERR);
        wr(HOLE, 32'hff, `WDT_RESP_SLVERR);
        rd(CTRL, 32'h00, `WDT_RESP_OKAY);
        // Every overflow select and standby code stored while stopped
        for (int s = 0; s < 8; s++) begin
            wr(CTRL, {24'h0, 3'b000, 2'(s), 3'(s)}, `WDT_RESP_OKAY);
            rd(CTRL, {24'h0, 3'b000, 2'(s), 3'(s)}, `WDT_RESP_OKAY);
        end
        // Flag written by software, cleared by each outer reset source
        for (int k = 0; k < 3; k++) begin
            wr(CTRL, 32'h9f, `WDT_RESP_OKAY);
            rd(CTRL, 32'h9f, `WDT_RESP_OKAY);
            @(posedge clk);
            external_reset_pin_n <= (k != 0);
            power_on_reset <= (k == 1);
            low_voltage_reset <= (k == 2);
            repeat (6) @(posedge clk);
            external_reset_pin_n <= 1'b1;
            power_on_reset <= 1'b0;
            low_voltage_reset <= 1'b0;
            repeat (4) @(posedge clk);
            rd(CTRL, 32'h00, `WDT_RESP_OKAY);
        end
        // Start, lock, overflow at 512 ticks
        wr(CTRL, 32'h38, `WDT_RESP_OKAY);
        repeat (4) @(posedge clk);
        check(32'(rc_osc_enable), 32'h1);
        wr(CTRL, 32'h00, `WDT_RESP_OKAY);
        rd(CTRL, 32'h38, `WDT_RESP_OKAY);
        // Standby code 11 keeps counting
        standby_active <= 1'b1;
        ticks(511);
        check(pulses, 32'h0);
        check(32'(rc_osc_enable), 32'h1);
        ticks(1);
        check(pulses, 32'h1);
        standby_active <= 1'b0;
        rd(CTRL, 32'h98, `WDT_RESP_OKAY);
        check(32'(rc_osc_enable), 32'h0);
        // Select 1: 55h through the control address is not a restart
        wr(CTRL, 32'h21, `WDT_RESP_OKAY);
        ticks(1000);
        wr(CTRL, 32'h55, `WDT_RESP_OKAY);
        ticks(23);
        check(pulses, 32'h1);
        ticks(1);
        check(pulses, 32'h2);
        rd(CTRL, 32'h81, `WDT_RESP_OKAY);
        // Restart write clears the count and keeps stored bits
        wr(CTRL, 32'h20, `WDT_RESP_OKAY);
        ticks(500);
        wr(RESTART, 32'h55, `WDT_RESP_OKAY);
        rd(CTRL, 32'h20, `WDT_RESP_OKAY);
        rd(RESTART, 32'h00, `WDT_RESP_OKAY);
        ticks(511);
        check(pulses, 32'h2);
        ticks(1);
        check(pulses, 32'h3);
        wr(RESTART, 32'h55, `WDT_RESP_OKAY);
        rd(CTRL, 32'h80, `WDT_RESP_OKAY);
        // Hold selection freezes count and oscillator in standby
        wr(CTRL, 32'h30, `WDT_RESP_OKAY);
        ticks(300);
        standby_active <= 1'b1;
        repeat (4) @(posedge clk);
        check(32'(rc_osc_enable), 32'h0);
        ticks(600);
        check(pulses, 32'h3);
        standby_active <= 1'b0;
        repeat (4) @(posedge clk);
        check(32'(rc_osc_enable), 32'h1);
        // Early re-entry in hold mode keeps the oscillator on, count frozen
        standby_active <= 1'b1;
        repeat (4) @(posedge clk);
        check(32'(rc_osc_enable), 32'h1);
        ticks(50);
        check(pulses, 32'h3);
        standby_active <= 1'b0;
        repeat (4) @(posedge clk);
        ticks(211);
        check(pulses, 32'h3);
        ticks(1);
        check(pulses, 32'h4);
        // Continue selection keeps counting in standby
        wr(CTRL, 32'h20, `WDT_RESP_OKAY);
        standby_active <= 1'b1;
        ticks(511);
        check(32'(rc_osc_enable), 32'h1);
        ticks(1);
        check(pulses, 32'h5);
        standby_active <= 1'b0;
        // Stop selection halts counting in standby
        wr(CTRL, 32'h28, `WDT_RESP_OKAY);
        standby_active <= 1'b1;
        ticks(600);
        check(pulses, 32'h5);
        standby_active <= 1'b0;
        ticks(512);
        check(pulses, 32'h6);
        finish_test();
    end

    // Cuts a hang short
    initial begin
        repeat (90000) @(posedge clk);
        n_errors++;
        finish_test();
    end

endmodule : test_watchdog_reset_timer
